// ---- logic/atpg_pkg.sv ----
// Functional notes
// [RQ1] The channel B select field picks its source: 0000 samples, 0001 all zeros, 0010 all ones.
// [RQ2] The chosen 16-bit word goes to the link in place of samples, with the two low bits zeroed in the 14-bit variant.
// [RQ3] Code 0011 alternates per sample between 1010...10 and its complement 0101...01.
// [RQ4] Code 0100 in the 16-bit variant is a ramp rising by one per sample from 0 to 65535.
// [RQ5] In the 14-bit variant the ramp rises by one every fourth sample from 0 to 16383.
// [RQ6] Code 0110 outputs user word one, bits 15:0 or bits 15:2 depending on the variant.
// [RQ7] Code 0111 alternates per sample between user word one and user word two.
// [RQ8] Code 1000 outputs the deskew word AAAAh, or 3AAAh in the 14-bit variant.
// [RQ9] Code 1010 outputs a pseudo-random sequence instead of samples.
// [RQ10] Code 1011 in the 16-bit variant repeats 1, 9598, 32768, 55938, 65535, 55938, 32768, 9598.
// [RQ11] In the 14-bit variant the sine repeats 0, 2399, 8192, 13984, 16383, 13984, 8192, 2399.
// [RQ12] User word one is the byte at 10h (high) and 11h (low), shared by both channels.
// [RQ13] User word two is the byte at 12h (high) and 13h (low), shared by both channels.
// [RQ14] The four user word bytes are read/write and reset to zero.
// [RQ15] Channel A has its own select field in bits 7:4 of the same register with the same codes.
// [RQ16] Unused codes should not be programmed and fall back to passing samples.
// [RQ17] The pseudo-random source is a maximal-length LFSR stepping once per sample, per channel.
package atpg_pkg;

	typedef struct packed {
		logic [15:0] cha;
		logic [15:0] chb;
	} atpg_pair_t;

	// Printed offsets are register indices; byte address is four times
	localparam logic [7:0] ATPG_IDX_SEL     = 8'h0f;
	localparam logic [7:0] ATPG_IDX_U1_HI   = 8'h10;
	localparam logic [7:0] ATPG_IDX_U1_LO   = 8'h11;
	localparam logic [7:0] ATPG_IDX_U2_HI   = 8'h12;
	localparam logic [7:0] ATPG_IDX_U2_LO   = 8'h13;
	localparam logic [7:0] ATPG_IDX_STATUS  = 8'h14;

	localparam logic [7:0] ATPG_RST_BYTE    = 8'h00;
	localparam int         ATPG_SEL_A_LSB   = 4;
	localparam int         ATPG_SEL_B_LSB   = 0;

	localparam logic [3:0] ATPG_PAT_NORMAL  = 4'h0;
	localparam logic [3:0] ATPG_PAT_ZEROS   = 4'h1;
	localparam logic [3:0] ATPG_PAT_ONES    = 4'h2;
	localparam logic [3:0] ATPG_PAT_TOGGLE  = 4'h3;
	localparam logic [3:0] ATPG_PAT_RAMP    = 4'h4;
	localparam logic [3:0] ATPG_PAT_SINGLE  = 4'h6;
	localparam logic [3:0] ATPG_PAT_DOUBLE  = 4'h7;
	localparam logic [3:0] ATPG_PAT_DESKEW  = 4'h8;
	localparam logic [3:0] ATPG_PAT_PRBS    = 4'ha;
	localparam logic [3:0] ATPG_PAT_SINE    = 4'hb;

	localparam logic [15:0] ATPG_TOGGLE_W   = 16'haaaa;
	localparam logic [15:0] ATPG_DESKEW16   = 16'haaaa;
	localparam logic [13:0] ATPG_DESKEW14   = 14'h3aaa;
	localparam logic [15:0] ATPG_MASK16     = 16'hffff;
	localparam logic [15:0] ATPG_MASK14     = 16'hfffc;
	localparam logic [15:0] ATPG_RAMP_LIM14 = 16'h3fff;
	localparam logic [1:0]  ATPG_RAMP_DIV   = 2'h3;
	localparam logic [15:0] ATPG_PRBS_SEED  = 16'h0001;
	// Taps of x^16 + x^14 + x^13 + x^11 + 1
	localparam logic [15:0] ATPG_PRBS_TAPS  = 16'hb400;

	localparam logic [15:0] ATPG_SINE16 [8] = '{16'h0001, 16'h257e,
		16'h8000, 16'hda82, 16'hffff, 16'hda82, 16'h8000, 16'h257e};
	localparam logic [13:0] ATPG_SINE14 [8] = '{14'h0000, 14'h095f,
		14'h2000, 14'h36a0, 14'h3fff, 14'h36a0, 14'h2000, 14'h095f};

	localparam int ATPG_FIFO_DEPTH = 4;
	localparam int ATPG_FIFO_WIDTH = 32;

endpackage

// ---- logic/atpg_top.sv ----
`timescale 1ns/100ps

module atpg_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_i,       // Clock
	input  wire logic             sys_rst_i,   // Sync reset, high
	input  wire logic [WIDTH-1:0] in_data_i,   // Write word
	input  wire logic             in_valid_i,  // Write request
	output logic                  in_ready_o,  // Room for a word
	output logic      [WIDTH-1:0] out_data_o,  // Head word
	output logic                  out_valid_o, // Head valid
	input  wire logic             out_ready_i, // Head taken
	output logic      [$clog2(DEPTH+1)-1:0] count_o // Fill level
);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [CW-1:0]    count_q;
	logic [CW-1:0]    count_d;
	logic             ready_q;
	logic             valid_q;
	logic             push;
	logic             pop;

	assign push = in_valid_i & ready_q;
	assign pop  = valid_q & out_ready_i;

	always_comb
	begin
		count_d = count_q;
		if (push & ~pop)
			count_d = count_q + CW'(1);
		else if (pop & ~push)
			count_d = count_q - CW'(1);
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			count_q <= '0;
			ready_q <= 1'b1;
			valid_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			ready_q <= (count_d != CW'(DEPTH));
			valid_q <= (count_d != '0);
		end
	end

	// Shift register: head always sits in entry zero
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++)
		begin : g_ent
			logic [WIDTH-1:0] nxt;
			if (i < DEPTH - 1)
			begin : g_mid
				assign nxt = mem_q[i+1];
			end
			else
			begin : g_last
				assign nxt = mem_q[i];
			end
			always_ff @(posedge clk_i)
			begin
				if (sys_rst_i)
					mem_q[i] <= '0;
				else if (pop)
					mem_q[i] <= (push && count_q == CW'(i + 1))
						? in_data_i : nxt;
				else if (push && count_q == CW'(i))
					mem_q[i] <= in_data_i;
			end
		end
	endgenerate

	assign in_ready_o  = ready_q;
	assign out_valid_o = valid_q;
	assign out_data_o  = mem_q[0];
	assign count_o     = count_q;
endmodule

module atpg_top
	import atpg_pkg::*;
#(
	parameter bit VARIANT_14BIT = 1'b0
) (
	input  wire logic        clk_i,          // 125 MHz clock
	input  wire logic        sys_rst_i,      // Sync reset, high
	input  wire logic        psel_i,         // APB select
	input  wire logic        penable_i,      // APB enable
	input  wire logic        pwrite_i,       // APB write
	input  wire logic [7:0]  paddr_i,        // APB byte address
	input  wire logic [31:0] pwdata_i,       // APB write data
	output logic      [31:0] prdata_o,       // APB read data
	output logic             pready_o,       // APB ready
	output logic             pslverr_o,      // APB error
	input  wire atpg_pair_t  sample_i,       // Converted samples
	input  wire logic        sample_valid_i, // Sample pair valid
	output logic             sample_ready_o, // Sample pair taken
	output atpg_pair_t       link_data_o,    // Words to the link
	output logic             link_valid_o,   // Link word valid
	input  wire logic        link_ready_i    // Link accepts word
);
	localparam logic [15:0] MASK = VARIANT_14BIT ? ATPG_MASK14
		: ATPG_MASK16;

	logic [7:0]  pattern_select_q;
	logic [7:0]  user_word_one_high_q;
	logic [7:0]  user_word_one_low_q;
	logic [7:0]  user_word_two_high_q;
	logic [7:0]  user_word_two_low_q;
	logic [15:0] user_word_one;
	logic [15:0] user_word_two;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        apb_req;
	logic        apb_wr;
	logic [5:0]  idx;
	logic        idx_ok;
	logic [31:0] rd_val;
	logic        fifo_ready;
	logic [2:0]  fifo_count;
	logic        step;
	logic [15:0] word [2];
	atpg_pair_t  gen_pair;

	assign user_word_one = {user_word_one_high_q, user_word_one_low_q}; // [RQ12]
	assign user_word_two = {user_word_two_high_q, user_word_two_low_q}; // [RQ13]

	// APB: one wait state, write lands at the edge that samples pready
	assign apb_req = psel_i & penable_i;
	assign apb_wr  = apb_req & pready_q & pwrite_i & ~pslverr_q;
	assign idx     = paddr_i[7:2];

	always_comb
	begin
		idx_ok = 1'b1;
		rd_val = '0;
		case ({2'b00, idx})
			ATPG_IDX_SEL:    rd_val[7:0] = pattern_select_q;
			ATPG_IDX_U1_HI:  rd_val[7:0] = user_word_one_high_q; // [RQ14]
			ATPG_IDX_U1_LO:  rd_val[7:0] = user_word_one_low_q;
			ATPG_IDX_U2_HI:  rd_val[7:0] = user_word_two_high_q;
			ATPG_IDX_U2_LO:  rd_val[7:0] = user_word_two_low_q;
			ATPG_IDX_STATUS: rd_val[4:0] = {~fifo_ready, fifo_count,
				link_valid_o};
			default:         idx_ok = 1'b0;
		endcase
		if (paddr_i[1:0] != 2'b00)
			idx_ok = 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end
		else
		begin
			pready_q  <= apb_req & ~pready_q;
			pslverr_q <= apb_req & ~pready_q & ~idx_ok;
			if (apb_req & ~pready_q)
				prdata_q <= (pwrite_i | ~idx_ok) ? '0 : rd_val;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			pattern_select_q     <= ATPG_RST_BYTE;
			user_word_one_high_q <= ATPG_RST_BYTE; // [RQ14]
			user_word_one_low_q  <= ATPG_RST_BYTE;
			user_word_two_high_q <= ATPG_RST_BYTE;
			user_word_two_low_q  <= ATPG_RST_BYTE;
		end
		else if (apb_wr)
		begin
			case ({2'b00, idx})
				ATPG_IDX_SEL:   pattern_select_q     <= pwdata_i[7:0];
				ATPG_IDX_U1_HI: user_word_one_high_q <= pwdata_i[7:0];
				ATPG_IDX_U1_LO: user_word_one_low_q  <= pwdata_i[7:0];
				ATPG_IDX_U2_HI: user_word_two_high_q <= pwdata_i[7:0];
				ATPG_IDX_U2_LO: user_word_two_low_q  <= pwdata_i[7:0];
				default:        pattern_select_q     <= pattern_select_q;
			endcase
		end
	end

	assign step = sample_valid_i & fifo_ready;

	// Channel 0 is A (select bits 7:4), channel 1 is B (bits 3:0)
	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_ch
			localparam int LSB = (c == 0) ? ATPG_SEL_A_LSB
				: ATPG_SEL_B_LSB;
			logic [3:0]  sel;
			logic [15:0] smp;
			logic [15:0] raw;
			logic        tog_q;
			logic        dbl_q;
			logic [15:0] ramp_q;
			logic [1:0]  div_q;
			logic [15:0] prbs_q;
			logic [2:0]  sine_q;

			assign sel = pattern_select_q[LSB +: 4]; // [RQ15]
			assign smp = (c == 0) ? sample_i.cha : sample_i.chb;

			always_ff @(posedge clk_i)
			begin
				if (sys_rst_i)
				begin
					tog_q  <= 1'b0;
					dbl_q  <= 1'b0;
					sine_q <= '0;
				end
				else if (step)
				begin
					tog_q  <= ~tog_q;  // [RQ3]
					dbl_q  <= ~dbl_q;  // [RQ7]
					sine_q <= sine_q + 3'h1; // [RQ10] [RQ11]
				end
			end

			always_ff @(posedge clk_i)
			begin
				if (sys_rst_i)
				begin
					ramp_q <= '0;
					div_q  <= '0;
				end
				else if (step)
				begin
					div_q <= div_q + 2'h1;
					if (!VARIANT_14BIT)
						ramp_q <= ramp_q + 16'h0001; // [RQ4]
					else if (div_q == ATPG_RAMP_DIV)
						ramp_q <= (ramp_q + 16'h0001)
							& ATPG_RAMP_LIM14; // [RQ5]
				end
			end

			// Galois LFSR, one shift per sample
			always_ff @(posedge clk_i)
			begin
				if (sys_rst_i)
					prbs_q <= ATPG_PRBS_SEED;
				else if (step)
					prbs_q <= prbs_q[0]
						? ((prbs_q >> 1) ^ ATPG_PRBS_TAPS)
						: (prbs_q >> 1); // [RQ17]
			end

			always_comb
			begin
				case (sel) // [RQ1]
					ATPG_PAT_NORMAL: raw = smp;
					ATPG_PAT_ZEROS:  raw = '0;
					ATPG_PAT_ONES:   raw = '1;
					ATPG_PAT_TOGGLE: raw = tog_q ? ~ATPG_TOGGLE_W
						: ATPG_TOGGLE_W; // [RQ3]
					ATPG_PAT_RAMP:   raw = VARIANT_14BIT
						? {ramp_q[13:0], 2'b00} : ramp_q; // [RQ4] [RQ5]
					ATPG_PAT_SINGLE: raw = user_word_one; // [RQ6]
					ATPG_PAT_DOUBLE: raw = dbl_q ? user_word_two
						: user_word_one; // [RQ7]
					ATPG_PAT_DESKEW: raw = VARIANT_14BIT
						? {ATPG_DESKEW14, 2'b00} : ATPG_DESKEW16; // [RQ8]
					ATPG_PAT_PRBS:   raw = prbs_q; // [RQ9]
					ATPG_PAT_SINE:   raw = VARIANT_14BIT
						? {ATPG_SINE14[sine_q], 2'b00}
						: ATPG_SINE16[sine_q]; // [RQ10] [RQ11]
					default:         raw = smp; // [RQ16]
				endcase
			end

			assign word[c] = raw & MASK; // [RQ2]
		end
	endgenerate

	assign gen_pair.cha = word[0];
	assign gen_pair.chb = word[1];

	atpg_fifo #(
		.WIDTH (ATPG_FIFO_WIDTH),
		.DEPTH (ATPG_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_data_i   (gen_pair),
		.in_valid_i  (sample_valid_i),
		.in_ready_o  (fifo_ready),
		.out_data_o  (link_data_o), // [RQ2]
		.out_valid_o (link_valid_o),
		.out_ready_i (link_ready_i),
		.count_o     (fifo_count)
	);

	assign sample_ready_o = fifo_ready;
	assign prdata_o       = prdata_q;
	assign pready_o       = pready_q;
	assign pslverr_o      = pslverr_q;
endmodule

// ---- verification/atpg_link_sink.sv ----
`timescale 1ns/100ps

module atpg_link_sink (
	input  wire logic       clk_i,   // Clock
	input  wire logic [1:0] mode_i,  // 0 fast, 1 slow, 2 stalled
	output logic            ready_o  // Link takes word
);
	// Link pace: always ready, random gaps, or held off
	initial ready_o = 1'b0;
	always @(posedge clk_i)
	begin
		case (mode_i)
			2'h0: ready_o <= 1'b1;
			2'h1: ready_o <= ($urandom % 4) == 0;
			default: ready_o <= 1'b0;
		endcase
	end
endmodule

// ---- verification/atpg_assertions.sv ----
`timescale 1ns/100ps

module atpg_checker
	import atpg_pkg::*;
#(
	parameter bit VARIANT_14BIT = 1'b0
) (
	input wire logic        clk_i,          // Clock
	input wire logic        sys_rst_i,      // Reset
	input wire logic        psel_i,         // Select
	input wire logic        penable_i,      // Enable
	input wire logic        pwrite_i,       // Write
	input wire logic [7:0]  paddr_i,        // Address
	input wire logic [31:0] pwdata_i,       // Write data
	input wire logic [31:0] prdata_o,       // Read data
	input wire logic        pready_o,       // Ready
	input wire logic        pslverr_o,      // Error
	input wire atpg_pair_t  sample_i,       // Samples
	input wire logic        sample_valid_i, // Sample valid
	input wire logic        sample_ready_o, // Sample ready
	input wire atpg_pair_t  link_data_o,    // Link word
	input wire logic        link_valid_o,   // Link valid
	input wire logic        link_ready_i    // Link ready
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence acc_s;
		psel_i && penable_i && !pready_o && !$past(penable_i);
	endsequence
	sequence held_s;
		link_valid_o && !link_ready_i;
	endsequence
	apb_answer_a: assert property (acc_s |=> pready_o)
		else $error("APB answer not one cycle after access");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("APB ready longer than one cycle");
	ready_access_a: assert property (pready_o |-> psel_i && penable_i)
		else $error("APB ready outside access");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("APB error without ready");
	read_byte_a: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
		else $error("Read data upper bits set");
	link_hold_a: assert property (held_s |=> link_valid_o && $stable(link_data_o))
		else $error("Link word changed while stalled");
	low_bits_a: assert property (link_valid_o && VARIANT_14BIT |-> link_data_o.cha[1:0] == 2'h0 && link_data_o.chb[1:0] == 2'h0)
		else $error("Low bits not zero in 14-bit variant");
	first_word_a: assert property (sample_valid_i && sample_ready_o |=> link_valid_o)
		else $error("Accepted sample not offered to link");
	full_valid_a: assert property (!sample_ready_o |-> link_valid_o)
		else $error("Refusing samples with empty buffer");
endmodule

bind atpg_top atpg_checker #(.VARIANT_14BIT(VARIANT_14BIT)) u_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .sample_i(sample_i),
	.sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
	.link_data_o(link_data_o), .link_valid_o(link_valid_o),
	.link_ready_i(link_ready_i)
);

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps

module tb_top
	import atpg_pkg::*;
;
	logic clk, rst, psel, pen, pwr, sv, lrdy;
	logic [7:0] pa, sel;
	logic [31:0] pwd;
	logic [1:0] smode;
	atpg_pair_t si;
	logic [31:0] prd [2];
	logic prdy [2], perr [2], srdy [2], lv [2];
	atpg_pair_t ld [2];
	logic [15:0] u1, u2, ps;
	logic [31:0] q0 [$], q1 [$];
	int n, fails, n_compared, k;
	localparam logic [3:0] CD [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
		4'h6, 4'h7, 4'h8, 4'ha, 4'hb, 4'h5, 4'h9, 4'hc, 4'hf};
	localparam logic [7:0] RA [7] = '{8'h3c, 8'h40, 8'h44, 8'h48, 8'h4c,
		8'h54, 8'h41};

	for (genvar v = 0; v < 2; v++)
	begin : g
		atpg_top #(.VARIANT_14BIT(v == 1)) DUT (
			.clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
			.pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd[v]),
			.pready_o(prdy[v]), .pslverr_o(perr[v]), .sample_i(si),
			.sample_valid_i(sv), .sample_ready_o(srdy[v]),
			.link_data_o(ld[v]), .link_valid_o(lv[v]), .link_ready_i(lrdy));
	end
	atpg_link_sink u_sink (.clk_i(clk), .mode_i(smode), .ready_o(lrdy));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	function automatic logic [15:0] ex(logic [3:0] c, bit v, logic [15:0] s);
		logic [15:0] r;
		case (c)
			4'h0: r = s;
			4'h1: r = 16'h0000;
			4'h2: r = 16'hffff;
			4'h3: r = n[0] ? ~ATPG_TOGGLE_W : ATPG_TOGGLE_W;
			4'h4: r = v ? 16'(((n >> 2) % 16384) << 2) : 16'(n);
			4'h6: r = u1;
			4'h7: r = n[0] ? u2 : u1;
			4'h8: r = v ? {ATPG_DESKEW14, 2'h0} : ATPG_DESKEW16;
			4'ha: r = ps;
			4'hb: r = v ? {ATPG_SINE14[n % 8], 2'h0} : ATPG_SINE16[n % 8];
			default: r = s;
		endcase
		return v ? (r & 16'hfffc) : r;
	endfunction

	// Reference stream: expected words queued at acceptance
	always @(posedge clk)
	begin
		if (!rst && lv[0] && lrdy)
		begin
			if (q0.size() == 0)
				chk(32'h1, 32'h0);
			else
			begin
				chk(ld[0], q0.pop_front());
				chk(ld[1], q1.pop_front());
			end
		end
		if (!rst && sv && srdy[0])
		begin
			q0.push_back({ex(sel[7:4], 0, si.cha), ex(sel[3:0], 0, si.chb)});
			q1.push_back({ex(sel[7:4], 1, si.cha), ex(sel[3:0], 1, si.chb)});
			n++;
			ps = ps[0] ? ((ps >> 1) ^ 16'hb400) : (ps >> 1);
		end
	end

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic bad;
		logic [31:0] x;
		int i;
		bad = !(a inside {8'h3c, 8'h40, 8'h44, 8'h48, 8'h4c, 8'h50});
		case (a)
			8'h3c: x = sel;
			8'h40: x = u1[15:8];
			8'h44: x = u1[7:0];
			8'h48: x = u2[15:8];
			8'h4c: x = u2[7:0];
			8'h50: x = 32'({q0.size() == ATPG_FIFO_DEPTH, 3'(q0.size()),
				q0.size() != 0});
			default: x = 32'h0;
		endcase
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end while (prdy[0] !== 1'b1 && i < 20);
		if (i >= 20)
		begin
			fails++;
			conclude;
		end
		chk(32'(perr[0]), 32'(bad));
		chk(32'(perr[1]), 32'(bad));
		if (!w)
		begin
			chk(prd[0], x);
			chk(prd[1], x);
		end
		if (w && !bad)
		begin
			case (a)
				8'h3c: sel = d[7:0];
				8'h40: u1[15:8] = d[7:0];
				8'h44: u1[7:0] = d[7:0];
				8'h48: u2[15:8] = d[7:0];
				8'h4c: u2[7:0] = d[7:0];
				default: ;
			endcase
		end
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task stream(input int cnt);
		int i, m;
		m = n + cnt;
		for (i = 0; i < 400 && n < m; i++)
		begin
			@(posedge clk);
			sv <= ($urandom % 4) != 0;
			si <= $urandom;
		end
		@(posedge clk);
		sv <= 1'b0;
		for (i = 0; i < 200 && (q0.size() > 0 || n < m); i++)
			@(posedge clk);
		if (i >= 200)
		begin
			fails++;
			conclude;
		end
	endtask

	initial
	begin
		void'($urandom(23287));
		{rst, psel, pen, pwr, pa, pwd, sv, si, smode} = '0;
		rst = 1'b1;
		{sel, u1, u2, n, fails, n_compared} = '0;
		ps = 16'h0001;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (RA[j])
			apb(1'b0, RA[j], 32'h0);
		foreach (RA[j])
		begin
			apb(1'b1, RA[j], $urandom);
			apb(1'b0, RA[j], 32'h0);
		end
		apb(1'b1, 8'h50, 32'h0);
		for (k = 0; k < 14; k++)
		begin
			smode <= 2'(k % 2);
			apb(1'b1, 8'h3c, {24'h0, CD[(k + 3) % 14], CD[k]});
			stream(12);
		end
		// Stalled link: buffer of four fills and refuses
		smode <= 2'h2;
		@(posedge clk);
		sv <= 1'b1;
		repeat (6) @(posedge clk);
		chk(32'(srdy[0]), 32'h0);
		chk(q0.size(), ATPG_FIFO_DEPTH);
		// Fill level seen through the status word while stalled
		apb(1'b0, 8'h50, 32'h0);
		smode <= 2'h1;
		stream(0);
		conclude;
	end
endmodule
